// ===== aacg_defines.svh
// register offsets, reset values and field positions of the audio clock block
`ifndef AACG_DEFINES_SVH
`define AACG_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define AACG_ADDR_CAPTURE_HIGH 16'hffe3
`define AACG_ADDR_CAPTURE_LOW  16'hffe4
`define AACG_ADDR_SYNTH1_HIGH  16'hffe5
`define AACG_ADDR_SYNTH1_MID   16'hffe6
`define AACG_ADDR_SYNTH1_LOW   16'hffe7

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define AACG_BYTE_RESET        8'h00
`define AACG_WORD_RESET        24'h000000
`define AACG_COUNT_RESET       16'h0000
`define AACG_UNMAPPED_READ     8'h00
`define AACG_FREQ_MSB          23
`define AACG_CAP_HIGH_MSB      15
`define AACG_CAP_HIGH_LSB      8
`define AACG_CAP_LOW_MSB       7

`endif

// ===== aacg_pkg.sv
// shared types of the audio clock block
package aacg_pkg;

    // one register byte of the microcontroller bus
    typedef logic [7:0] aacg_byte_t;

    // which synthesizer drives a master clock path
    typedef enum logic {
        AACG_SRC_PRIMARY,
        AACG_SRC_SECOND
    } aacg_src_t;

endpackage

// ===== aacg_cap_if.sv
// link between the clock logic and the frame capture counter
`timescale 1ns/1ps
`default_nettype none

interface aacg_cap_if #(
    parameter int CNT_W = 16
);
    logic             tick;   // one master clock rising edge seen
    logic             sof;    // start of frame pulse
    logic [CNT_W-1:0] count;  // captured counter snapshot

    modport src (output tick, output sof, input count);
    modport cap (input tick, input sof, output count);
endinterface

`default_nettype wire

// ===== aacg_capture.sv
// free running master clock counter with start of frame snapshot
`timescale 1ns/1ps
`default_nettype none
`include "aacg_defines.svh"

module aacg_capture #(
    parameter int CNT_W = 16
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_clk_en,
    aacg_cap_if.cap   cap
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] cap_ff;

    // ****************************************************************
    // free running counter
    // ****************************************************************
    // wraps to zero by plain overflow, never stops
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_ff <= `AACG_COUNT_RESET;
        end else if (i_clk_en && cap.tick) begin
            cnt_ff <= CNT_W'(cnt_ff + 1'b1);
        end
    end

    // ****************************************************************
    // frame snapshot
    // ****************************************************************
    // one register for both bytes keeps the halves from one sample;
    // a tick in the sof cycle lands in the next frame's count
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cap_ff <= `AACG_COUNT_RESET;
        end else if (i_clk_en && cap.sof) begin
            cap_ff <= cnt_ff;
        end
    end

    assign cap.count = cap_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    AST_CNT_STEPS: assert property (
        (i_clk_en && cap.tick) |=> cnt_ff == CNT_W'($past(cnt_ff) + 1'b1))
        else $error("counter did not step on master clock edge");
    AST_CNT_STILL: assert property (
        !(i_clk_en && cap.tick) |=> $stable(cnt_ff))
        else $error("counter moved without a master clock edge");
    AST_CAP_LOAD: assert property (
        (i_clk_en && cap.sof) |=> cap_ff == $past(cnt_ff))
        else $error("capture missed the counter at start of frame");
    AST_CAP_HOLD: assert property (
        !(i_clk_en && cap.sof) |=> $stable(cap_ff))
        else $error("capture changed between frames");

endmodule

`default_nettype wire

// ===== aacg_top.sv
// adaptive audio clock generator registers, synthesizer and capture
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "aacg_defines.svh"

module aacg_top #(
    parameter int FREQ_W = 24,
    parameter int CNT_W  = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_sof,
    input  wire logic        i_second_master_clock_out,
    input  wire logic        i_codec_clock_source_sel,
    input  wire logic        i_count_clock_source_sel,
    output logic      [7:0]  o_rdata,
    output logic             o_primary_master_clock_out,
    output logic             o_codec_master_clock
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    // byte registers and capture map only serve these widths
    if (FREQ_W != 24 || CNT_W != 16) begin : g_width_check
        $error("aacg_top supports only FREQ_W 24 and CNT_W 16");
    end

    aacg_pkg::aacg_byte_t  freq_low_ff;
    aacg_pkg::aacg_byte_t  freq_mid_ff;
    aacg_pkg::aacg_byte_t  freq_high_ff;
    logic [FREQ_W-1:0]     frequency_word;
    logic [FREQ_W-1:0]     phase_ff;
    logic                  mclk_ff;
    logic                  mclk_prev_ff;
    logic                  sec_meta_ff;
    logic                  sec_sync_ff;
    logic                  sec_prev_ff;
    logic                  codec_mclk_ff;
    logic [7:0]            rdata_ff;
    logic                  primary_rise;
    logic                  second_rise;
    aacg_pkg::aacg_src_t   codec_src;
    aacg_pkg::aacg_src_t   count_src;

    aacg_cap_if #(.CNT_W(CNT_W)) cap_link ();

    // ****************************************************************
    // frequency word registers
    // ****************************************************************
    // writes land one edge after the strobe; the word is live at once
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            freq_low_ff  <= `AACG_BYTE_RESET;
            freq_mid_ff  <= `AACG_BYTE_RESET;
            freq_high_ff <= `AACG_BYTE_RESET;
        end else if (i_clk_en && i_wr) begin
            case (i_addr)
                `AACG_ADDR_SYNTH1_LOW:  freq_low_ff  <= i_wdata;
                `AACG_ADDR_SYNTH1_MID:  freq_mid_ff  <= i_wdata;
                `AACG_ADDR_SYNTH1_HIGH: freq_high_ff <= i_wdata;
                default: ;
            endcase
        end
    end

    // the three bytes are applied as written, no staging register;
    // firmware should change the word byte by byte with care
    assign frequency_word = {freq_high_ff, freq_mid_ff,
                             freq_low_ff};

    // ****************************************************************
    // primary synthesizer
    // ****************************************************************
    // phase accumulator: output rate is word / 2^24 of the bus clock,
    // so it can not exceed half the bus clock and jitters by one cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_ff <= `AACG_WORD_RESET;
            mclk_ff  <= 1'b0;
        end else if (i_clk_en) begin
            phase_ff <= FREQ_W'(phase_ff + frequency_word);
            mclk_ff  <= phase_ff[`AACG_FREQ_MSB];
        end
    end

    // ****************************************************************
    // second synthesizer input synchroniser
    // ****************************************************************
    // the second clock comes from outside this domain
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sec_meta_ff <= 1'b0;
            sec_sync_ff <= 1'b0;
        end else if (i_clk_en) begin
            sec_meta_ff <= i_second_master_clock_out;
            sec_sync_ff <= sec_meta_ff;
        end
    end

    // previous levels for edge detection on both sources
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sec_prev_ff  <= 1'b0;
            mclk_prev_ff <= 1'b0;
        end else if (i_clk_en) begin
            sec_prev_ff  <= sec_sync_ff;
            mclk_prev_ff <= mclk_ff;
        end
    end

    assign primary_rise = mclk_ff && !mclk_prev_ff;
    assign second_rise  = sec_sync_ff && !sec_prev_ff;

    // ****************************************************************
    // source selection
    // ****************************************************************
    assign codec_src = i_codec_clock_source_sel ? aacg_pkg::AACG_SRC_SECOND
                                                : aacg_pkg::AACG_SRC_PRIMARY;
    assign count_src = i_count_clock_source_sel ? aacg_pkg::AACG_SRC_SECOND
                                                : aacg_pkg::AACG_SRC_PRIMARY;

    // codec clock output, registered so the pin never glitches
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            codec_mclk_ff <= 1'b0;
        end else if (i_clk_en) begin
            case (codec_src)
                aacg_pkg::AACG_SRC_SECOND:  codec_mclk_ff <= sec_sync_ff;
                aacg_pkg::AACG_SRC_PRIMARY: codec_mclk_ff <= mclk_ff;
                default:                    codec_mclk_ff <= mclk_ff;
            endcase
        end
    end

    // counter tick from the chosen clock; sampled edges above half the
    // bus clock are lost, a limit of the single clock domain
    assign cap_link.tick = (count_src == aacg_pkg::AACG_SRC_SECOND)
                         ? second_rise : primary_rise;
    assign cap_link.sof  = i_sof;

    aacg_capture #(
        .CNT_W    (CNT_W)
    ) u_capture (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_clk_en (i_clk_en),
        .cap      (cap_link.cap)
    );

    // ****************************************************************
    // register read port
    // ****************************************************************
    // read data registered; unmapped addresses answer zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_ff <= `AACG_UNMAPPED_READ;
        end else if (i_clk_en && i_rd) begin
            case (i_addr)
                `AACG_ADDR_SYNTH1_LOW:  rdata_ff <= freq_low_ff;
                `AACG_ADDR_SYNTH1_MID:  rdata_ff <= freq_mid_ff;
                `AACG_ADDR_SYNTH1_HIGH: rdata_ff <= freq_high_ff;
                `AACG_ADDR_CAPTURE_LOW:
                    rdata_ff <= cap_link.count[`AACG_CAP_LOW_MSB:0];
                `AACG_ADDR_CAPTURE_HIGH:
                    rdata_ff <= cap_link.count[`AACG_CAP_HIGH_MSB:
                                               `AACG_CAP_HIGH_LSB];
                default: rdata_ff <= `AACG_UNMAPPED_READ;
            endcase
        end
    end

    assign o_rdata                    = rdata_ff;
    assign o_primary_master_clock_out = mclk_ff;
    assign o_codec_master_clock       = codec_mclk_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_write_low;
        i_clk_en && i_wr && i_addr == `AACG_ADDR_SYNTH1_LOW;
    endsequence
    sequence s_read_high;
        i_clk_en && i_rd && i_addr == `AACG_ADDR_CAPTURE_HIGH;
    endsequence
    sequence s_frame;
        i_clk_en && i_sof;
    endsequence

    AST_FREQ_WRITE: assert property (
        s_write_low |=> freq_low_ff == $past(i_wdata))
        else $error("low frequency byte not stored");
    AST_NCO_STEP: assert property (
        i_clk_en |=> phase_ff == FREQ_W'($past(phase_ff)
                                         + $past(frequency_word)))
        else $error("phase did not advance by the frequency word");
    AST_CODEC_SRC: assert property (
        (i_clk_en && i_codec_clock_source_sel)
            |=> codec_mclk_ff == $past(sec_sync_ff))
        else $error("codec clock not taken from second synthesizer");
    // follows the second clock edge, when chosen, into the counter itself, so a broken tick
    // path is caught and not only a broken select
    AST_TICK_SRC: assert property (
        (i_clk_en && i_count_clock_source_sel && second_rise)
            |=> u_capture.cnt_ff == CNT_W'($past(u_capture.cnt_ff) + 1'b1))
        else $error("counter tick not taken from second clock");
    AST_READ_HIGH: assert property (
        (s_read_high ##0 !i_sof) |=> o_rdata == $past(cap_link.count[15:8]))
        else $error("high capture byte read wrong");
    // both halves must equal the counter as it stood at the frame edge
    AST_COHERENT: assert property (
        s_frame |=> cap_link.count[15:8] == $past(u_capture.cnt_ff[15:8])
                    && cap_link.count[7:0] == $past(u_capture.cnt_ff[7:0]))
        else $error("capture bytes taken from different samples");

endmodule

`default_nettype wire

// ===== aacg_codec_model.sv
// behavioural codec that counts the master clock edges it receives
`timescale 1ns/1ps
`default_nettype none

module aacg_codec_model (
    input  wire logic   i_mclk,
    input  wire logic   i_clear,
    output logic [15:0] o_edges
);
    // ****************************************************************
    // master clock edge counter
    // ****************************************************************
    // the codec sees nothing but its clock pin, so a rate check is all it
    // can offer; clear is asynchronous because the clock may stand still
    always @(posedge i_mclk or posedge i_clear) begin
        if (i_clear) begin
            o_edges <= 16'h0000;
        end else begin
            o_edges <= o_edges + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// ===== adaptive_audio_clock_regs_test.sv
// self-checking bench of the adaptive audio clock register block
`timescale 1ns/1ps
`default_nettype none
`include "aacg_defines.svh"

module adaptive_audio_clock_regs_test;
    logic        i_clk, i_reset, i_clk_en, i_wr, i_rd, i_sof, sec_clk;
    logic        codec_sel, count_sel, model_clear;
    logic [15:0] i_addr, codec_edges;
    logic [7:0]  i_wdata, o_rdata;
    logic        codec_clk;
    logic        prim_clk;
    logic [15:0] prim_edges;
    int          errors, n_compared;

    aacg_top dut_u (
        .i_clk                      (i_clk),
        .i_reset                    (i_reset),
        .i_clk_en                   (i_clk_en),
        .i_addr                     (i_addr),
        .i_wr                       (i_wr),
        .i_rd                       (i_rd),
        .i_wdata                    (i_wdata),
        .i_sof                      (i_sof),
        .i_second_master_clock_out  (sec_clk),
        .i_codec_clock_source_sel   (codec_sel),
        .i_count_clock_source_sel   (count_sel),
        .o_rdata                    (o_rdata),
        .o_primary_master_clock_out (prim_clk),
        .o_codec_master_clock       (codec_clk)
    );

    aacg_codec_model codec_u (
        .i_mclk  (codec_clk),
        .i_clear (model_clear),
        .o_edges (codec_edges)
    );

    // a second copy counts the primary pin, so that output is judged too
    aacg_codec_model prim_u (
        .i_mclk  (prim_clk),
        .i_clear (model_clear),
        .o_edges (prim_edges)
    );

    // ****************************************************************
    // clocks
    // ****************************************************************
    always #25 i_clk = ~i_clk;
    // second synthesizer at 2 MHz, offset so it never lines up with i_clk
    initial begin
        sec_clk = 1'b0;
        #37;
        forever #250 sec_clk = ~sec_clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    // rate measurements carry one edge of slack for phase and sync delay
    task automatic near(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
        logic ok;
        ok = (seen + 16'h0001 >= exp) && (seen <= exp + 16'h0001);
        check({15'h0000, ok}, 16'h0001, msg);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_addr  = a;
        i_wdata = d;
        i_wr    = 1'b1;
        @(negedge i_clk);
        i_wr    = 1'b0;
    endtask

    task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_addr = a;
        i_rd   = 1'b1;
        @(negedge i_clk);
        i_rd   = 1'b0;
        d      = o_rdata;
    endtask

    task automatic sof_pulse;
        @(negedge i_clk);
        i_sof = 1'b1;
        @(negedge i_clk);
        i_sof = 1'b0;
    endtask

    task automatic measure(input int n, output logic [15:0] cnt);
        @(negedge i_clk);
        model_clear = 1'b1;
        @(negedge i_clk);
        model_clear = 1'b0;
        cycles(n);
        cnt = codec_edges;
    endtask

    task automatic read_capture(output logic [15:0] v);
        logic [7:0] lo, hi;
        bus_read(`AACG_ADDR_CAPTURE_LOW, lo);
        bus_read(`AACG_ADDR_CAPTURE_HIGH, hi);
        v = {hi, lo};
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_and_access;
        logic [15:0] addrs [6];
        logic [7:0]  vals [6];
        logic [7:0]  d;
        addrs = '{16'hffe3, 16'hffe4, 16'hffe5, 16'hffe6, 16'hffe7, 16'hffe0};
        vals  = '{8'h00, 8'h00, 8'hc3, 8'h5a, 8'ha5, 8'h00};
        foreach (addrs[i]) begin
            bus_read(addrs[i], d);
            check({8'h00, d}, 16'h0000, "reset");
        end
        // capture bytes and the hole get all ones, none of which may stick
        foreach (addrs[i]) bus_write(addrs[i], vals[i] | {8{i < 2 || i > 4}});
        foreach (addrs[i]) begin
            bus_read(addrs[i], d);
            check({8'h00, d}, {8'h00, vals[i]}, "write");
        end
    endtask

    task automatic t_synth_rate;
        logic [15:0] n;
        // firmware programs word 0x400000: output period of four bus cycles
        bus_write(`AACG_ADDR_SYNTH1_LOW, 8'h00);
        bus_write(`AACG_ADDR_SYNTH1_MID, 8'h00);
        bus_write(`AACG_ADDR_SYNTH1_HIGH, 8'h40);
        measure(40, n);
        near(n, 16'd10, "primary rate");
        i_clk_en = 1'b0;
        cycles(4);
        measure(40, n);
        check(n, 16'h0000, "frozen clock");
        i_clk_en = 1'b1;
        bus_write(`AACG_ADDR_SYNTH1_HIGH, 8'h00);
        cycles(4);
        measure(40, n);
        check(n, 16'h0000, "zero word");
        bus_write(`AACG_ADDR_SYNTH1_HIGH, 8'h40);
    endtask

    task automatic t_codec_source;
        logic [15:0] n;
        codec_sel = 1'b1;
        cycles(4);
        measure(200, n);
        near(n, 16'd20, "codec from second");
        near(prim_edges, 16'd50, "primary beside second");
        codec_sel = 1'b0;
        cycles(4);
        measure(40, n);
        near(n, 16'd10, "codec from primary");
    endtask

    task automatic t_capture(input logic sel, input logic [15:0] exp);
        logic [15:0] a, b, c;
        count_sel = sel;
        cycles(20);
        sof_pulse;
        read_capture(a);
        // frame edges land 404 bus cycles apart: 101 primary periods
        cycles(398);
        sof_pulse;
        read_capture(b);
        near(b - a, exp, "per frame");
        cycles(50);
        read_capture(c);
        check(c, b, "capture holds");
    endtask

    // a reset in mid run must clear programmed and captured bytes alike
    task automatic t_mid_reset;
        logic [7:0] d;
        i_reset = 1'b1;
        cycles(2);
        i_reset = 1'b0;
        for (logic [15:0] a = 16'hffe3; a <= 16'hffe7; a++) begin
            bus_read(a, d);
            check({8'h00, d}, 16'h0000, "reset again");
        end
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence and hang guard
    // ****************************************************************
    initial begin
        i_clk = 1'b0;
        i_reset = 1'b1;
        i_clk_en = 1'b1;
        {i_wr, i_rd, i_sof, codec_sel, count_sel, model_clear} = 6'h00;
        i_addr = 16'h0000;
        i_wdata = 8'h00;
        errors = 0;
        n_compared = 0;
        cycles(2);
        i_reset = 1'b0;
        t_reset_and_access;
        t_synth_rate;
        t_codec_source;
        t_capture(1'b0, 16'd101);
        t_capture(1'b1, 16'd40);
        t_mid_reset;
        complete_run;
    end

    initial begin
        #1000000;
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        complete_run;
    end
endmodule

`default_nettype wire
